// >>> dht_half.sv
/*
 * One split half: timer, edge counter, edge timer or PWM generator.
 * Assumes the top gates its enable off while the halves are joined.
 */
`timescale 1ns/1ps
module dht_half #(
	parameter int W = 16
) (
	input logic hclk,
	input logic hresetn,
	input logic [2:0] mode,
	input logic up,
	input dht_pkg::dht_ctl_s ctl,
	input logic halt,
	input logic chain_in,
	input logic cap_in,
	input logic [W-1:0] load,
	input logic load_wr,
	input logic [W-1:0] match,
	output logic [W-1:0] value,
	output logic [W-1:0] capture,
	output dht_pkg::dht_evt_s evt,
	output logic pwm_out,
	output logic trig_out
);
	dht_pkg::dht_run_e state, next_state;
	logic [W-1:0] next_value;
	logic cap_prev;

	wire rise = cap_in & ~cap_prev;
	wire fall = ~cap_in & cap_prev;
	wire edge_hit = (ctl.edge_sel == dht_pkg::rising_edge_select) ? rise :
		(ctl.edge_sel == dht_pkg::falling_edge_select) ? fall : (rise | fall);
	wire is_count = mode == dht_pkg::edge_count_capture_mode;
	wire is_time = mode == dht_pkg::edge_time_capture_mode;
	wire is_pwm = mode == dht_pkg::half_pwm_mode;
	wire is_oneshot = mode == dht_pkg::half_one_shot_mode;
	wire is_timer = ~is_count & ~is_time;
	wire go = (state == dht_pkg::hs_run) & ctl.en & ~(ctl.debug_freeze & halt);
	wire [31:0] step_w = dht_pkg::dht_step(32'(value), up);
	wire [W-1:0] stepped = step_w[W-1:0];
	wire [W-1:0] start_val = up ? {W{1'b0}} : load;
	wire at_end = up ? (value == load) : (value == {W{1'b0}});
	wire hit_match = stepped == match;
	wire tmo = go & is_timer & at_end;
	wire cnt_match = go & is_count & edge_hit & hit_match;
	wire time_evt = go & is_time & edge_hit;
	wire pwm_cmp = up ? (value < match) : (value > match);

	always_comb begin
		next_state = state;
		if (!ctl.en) begin
			next_state = dht_pkg::hs_idle;
		end else begin
			case (state)
				dht_pkg::hs_idle: next_state = ctl.wait_chain_start ? dht_pkg::hs_wait : dht_pkg::hs_run;
				dht_pkg::hs_wait: if (chain_in) next_state = dht_pkg::hs_run;
				dht_pkg::hs_run: if (tmo & is_oneshot) next_state = dht_pkg::hs_done;
				dht_pkg::hs_done: next_state = dht_pkg::hs_done;
				default: next_state = dht_pkg::hs_idle;
			endcase
		end
	end

	// Edge timing free-runs over the same interval as a periodic timer.
	always_comb begin
		next_value = value;
		if (load_wr) begin
			next_value = start_val;
		end else if (go) begin
			if (!is_count) begin
				if (at_end) begin
					next_value = is_oneshot ? value : start_val;
				end else begin
					next_value = stepped;
				end
			end else if (edge_hit) begin
				next_value = hit_match ? start_val : stepped;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= dht_pkg::hs_idle;
			value <= {W{1'b0}};
			capture <= {W{1'b0}};
			cap_prev <= 1'b0;
			evt <= 3'h0;
			pwm_out <= 1'b0;
			trig_out <= 1'b0;
		end else begin
			state <= next_state;
			value <= next_value;
			cap_prev <= cap_in;
			if (time_evt) begin
				capture <= value;
			end
			evt <= {time_evt, cnt_match, tmo};
			pwm_out <= (is_pwm & go & pwm_cmp) ^ ctl.invert;
			trig_out <= tmo & ctl.trig_en;
		end
	end
endmodule // dht_half

// >>> dht_pkg.sv
/*
 * Shared constants, types and helpers of the dual half timer.
 * Assumes a 32-bit register bus with word-aligned registers.
 */
package dht_pkg;
	localparam logic [7:0] reg_cfg = 8'h00;
	localparam logic [7:0] reg_ctrl = 8'h04;
	localparam logic [7:0] reg_load_a = 8'h08;
	localparam logic [7:0] reg_load_b = 8'h0c;
	localparam logic [7:0] reg_match_a = 8'h10;
	localparam logic [7:0] reg_match_b = 8'h14;
	localparam logic [7:0] reg_value_a = 8'h18;
	localparam logic [7:0] reg_value_b = 8'h1c;
	localparam logic [7:0] reg_status = 8'h20;
	localparam logic [7:0] reg_mask = 8'h24;
	localparam logic [7:0] reg_masked = 8'h28;
	localparam logic [7:0] reg_capture = 8'h2c;

	localparam int cfg_join_lsb = 0;
	localparam int cfg_up_bit = 3;
	localparam int cfg_mode_a_lsb = 4;
	localparam int cfg_mode_b_lsb = 8;
	localparam int cfg_half_up_ofs = 3;
	localparam int ctrl_sel_a_bit = 16;
	localparam int ctrl_sel_b_bit = 17;

	localparam logic [2:0] joined_one_shot_mode = 3'h0;
	localparam logic [2:0] joined_periodic_mode = 3'h1;
	localparam logic [2:0] joined_rtc_mode = 3'h2;
	localparam logic [2:0] split_pair_mode = 3'h4;

	localparam logic [2:0] half_one_shot_mode = 3'h0;
	localparam logic [2:0] half_periodic_mode = 3'h1;
	localparam logic [2:0] edge_count_capture_mode = 3'h2;
	localparam logic [2:0] edge_time_capture_mode = 3'h3;
	localparam logic [2:0] half_pwm_mode = 3'h4;

	localparam logic [1:0] rising_edge_select = 2'h0;
	localparam logic [1:0] falling_edge_select = 2'h1;
	localparam logic [1:0] both_edge_select = 2'h3;

	localparam logic [31:0] status_valid = 32'h0000070f;
	localparam logic [11:0] cfg_reset = 12'h000;
	localparam logic [31:0] word_reset = 32'h00000000;
	localparam int rtc_div_default = 32768;
	localparam int half_width = 16;

	typedef struct packed {
		logic wait_chain_start;
		logic trig_en;
		logic debug_freeze;
		logic invert;
		logic [1:0] edge_sel;
		logic en;
	} dht_ctl_s;

	typedef struct packed {
		logic cap_event;
		logic cap_match;
		logic timeout;
	} dht_evt_s;

	typedef enum logic [1:0] {hs_idle, hs_wait, hs_run, hs_done} dht_run_e;

	localparam dht_ctl_s ctl_reset = 7'h00;

	function automatic logic [31:0] dht_step(input logic [31:0] v, input logic up);
		return up ? v + 32'h00000001 : v - 32'h00000001;
	endfunction
endpackage

// >>> dht_timer.sv
/*
 * Dual half timer top: AHB-Lite register slave, joined 32-bit timer and RTC,
 * two split halves, interrupt status and mask.
 * Assumes a single AHB-Lite master, word accesses only, and all pins
 * synchronous to hclk, including the slow RTC reference.
 */
//
// Function
// - Configuration write stops both halves, stays stopped.
// - Joined mode: one-shot, periodic, up option, RTC.
// - Split halves each hold their own mode.
// - Halves do one-shot and periodic, up or down.
// - Halves count qualifying edges, up or down.
// - Halves capture counter value on qualifying edges.
// - PWM output polarity selectable by invert bit.
// - Capture edge: rising, falling or both.
// - Freeze bit stalls counting during debug halt.
// - Trigger enable gates timeout trigger pulse.
// - Wait bit holds start until chain input: trigger pin, or half A timeout for half B.
// - Enable bit starts or stops each half.
// - Reset returns everything to power-on state.
// - One-shot stops at end; periodic reloads.
// - RTC counts seconds from divided reference clock.
// - PWM mode turns capture pin into output.
// - Load write while running restarts counter immediately: at load value down, at zero up.
`timescale 1ns/1ps
module dht_timer #(
	parameter int RTC_DIV = dht_pkg::rtc_div_default,
	parameter int HALF_W = dht_pkg::half_width
) (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input logic debug_halt,
	input logic chain_trig_in,
	input logic rtc_clk_in,
	input logic cap_a_in,
	input logic cap_b_in,
	output logic cap_a_out,
	output logic cap_a_oe_n,
	output logic cap_b_out,
	output logic cap_b_oe_n,
	output logic trig_a,
	output logic trig_b,
	output logic irq
);
	logic [11:0] cfg;
	dht_pkg::dht_ctl_s ctl_a, ctl_b, hctl_a, hctl_b;
	logic [31:0] load_a, load_b, match_a, match_b, status, mask;
	logic [7:0] addr_q;
	logic wr_pend, rd_pend;
	dht_pkg::dht_run_e jstate, next_jstate;
	logic [31:0] jcnt, next_jcnt, div_cnt;
	logic rtc_prev;
	logic [HALF_W-1:0] val_a, val_b, cap_a, cap_b;
	dht_pkg::dht_evt_s evt_a, evt_b;
	logic pwm_a, pwm_b, htrig_a, htrig_b;

	// Mode decode.
	wire [2:0] join_mode = cfg[dht_pkg::cfg_join_lsb +: 3];
	wire split = join_mode == dht_pkg::split_pair_mode;
	wire is_rtc = join_mode == dht_pkg::joined_rtc_mode;
	wire j_oneshot = join_mode == dht_pkg::joined_one_shot_mode;
	wire j_up = cfg[dht_pkg::cfg_up_bit] & ~is_rtc;
	wire [2:0] mode_a = cfg[dht_pkg::cfg_mode_a_lsb +: 3];
	wire up_a = cfg[dht_pkg::cfg_mode_a_lsb + dht_pkg::cfg_half_up_ofs];
	wire [2:0] mode_b = cfg[dht_pkg::cfg_mode_b_lsb +: 3];
	wire up_b = cfg[dht_pkg::cfg_mode_b_lsb + dht_pkg::cfg_half_up_ofs];

	// Bus decode. Reads take one wait state so a read right after a write sees the new value.
	wire addr_ok = hsel & hready & htrans[1];
	wire wr_cfg = wr_pend & (addr_q == dht_pkg::reg_cfg);
	wire wr_ctrl = wr_pend & (addr_q == dht_pkg::reg_ctrl);
	wire wr_load_a = wr_pend & (addr_q == dht_pkg::reg_load_a);
	wire wr_load_b = wr_pend & (addr_q == dht_pkg::reg_load_b);
	wire wr_match_a = wr_pend & (addr_q == dht_pkg::reg_match_a);
	wire wr_match_b = wr_pend & (addr_q == dht_pkg::reg_match_b);
	wire wr_status = wr_pend & (addr_q == dht_pkg::reg_status);
	wire wr_mask = wr_pend & (addr_q == dht_pkg::reg_mask);
	wire ctrl_a_hit = wr_ctrl & hwdata[dht_pkg::ctrl_sel_a_bit];
	wire ctrl_b_hit = wr_ctrl & hwdata[dht_pkg::ctrl_sel_b_bit];
	wire [6:0] new_ctl = hwdata[6:0];

	// Halves run only while split; the joined counter owns half A's enable otherwise.
	assign hctl_a = {ctl_a[6:1], ctl_a.en & split};
	assign hctl_b = {ctl_b[6:1], ctl_b.en & split};
	wire [HALF_W-1:0] load_in_a = wr_load_a ? hwdata[HALF_W-1:0] : load_a[HALF_W-1:0];
	wire [HALF_W-1:0] load_in_b = wr_load_b ? hwdata[HALF_W-1:0] : load_b[HALF_W-1:0];

	// Joined counter and RTC.
	wire jen = ctl_a.en & ~split;
	// Gating with the enable stops the count from the cycle after a configuration write lands; the write's own cycle still steps it.
	wire jgo = (jstate == dht_pkg::hs_run) & jen & ~(ctl_a.debug_freeze & debug_halt);
	wire [31:0] jstep = dht_pkg::dht_step(jcnt, j_up);
	wire [31:0] jstart = j_up ? 32'h00000000 : load_a;
	wire jend = j_up ? (jcnt == load_a) : (jcnt == 32'h00000000);
	wire [31:0] rtc_next = jcnt + 32'h00000001;
	wire rtc_edge = rtc_clk_in & ~rtc_prev;
	wire sec_tick = rtc_edge & (div_cnt == 32'(RTC_DIV - 1));
	wire j_tmo = jgo & ~is_rtc & jend;
	wire rtc_hit = jgo & is_rtc & sec_tick & (rtc_next == match_a);

	// Status collection.
	wire [2:0] ev_a = split ? evt_a : {2'b00, j_tmo};
	wire [2:0] ev_b = split ? evt_b : 3'h0;
	wire [31:0] set_vec = {21'h000000, ev_b, 4'h0, rtc_hit, ev_a};
	wire [31:0] clr_vec = wr_status ? hwdata : 32'h00000000;
	wire [31:0] next_status = ((status & ~clr_vec) | set_vec) & dht_pkg::status_valid;

	// Read mux.
	wire [31:0] val_a_rd = split ? 32'(val_a) : jcnt;
	wire [31:0] val_b_rd = split ? 32'(val_b) : 32'h00000000;
	wire [31:0] cap_rd = {16'(cap_b), 16'(cap_a)};
	wire [31:0] rd_mux =
		(addr_q == dht_pkg::reg_cfg) ? {20'h00000, cfg} :
		(addr_q == dht_pkg::reg_ctrl) ? {17'h00000, ctl_b, 1'b0, ctl_a} :
		(addr_q == dht_pkg::reg_load_a) ? load_a :
		(addr_q == dht_pkg::reg_load_b) ? load_b :
		(addr_q == dht_pkg::reg_match_a) ? match_a :
		(addr_q == dht_pkg::reg_match_b) ? match_b :
		(addr_q == dht_pkg::reg_value_a) ? val_a_rd :
		(addr_q == dht_pkg::reg_value_b) ? val_b_rd :
		(addr_q == dht_pkg::reg_status) ? status :
		(addr_q == dht_pkg::reg_mask) ? mask :
		(addr_q == dht_pkg::reg_masked) ? (status & mask) :
		(addr_q == dht_pkg::reg_capture) ? cap_rd : 32'h00000000;

	always_comb begin
		next_jstate = jstate;
		if (!jen) begin
			next_jstate = dht_pkg::hs_idle;
		end else begin
			case (jstate)
				dht_pkg::hs_idle: next_jstate = ctl_a.wait_chain_start ? dht_pkg::hs_wait : dht_pkg::hs_run;
				dht_pkg::hs_wait: if (chain_trig_in) next_jstate = dht_pkg::hs_run;
				dht_pkg::hs_run: if (j_tmo & j_oneshot) next_jstate = dht_pkg::hs_done;
				dht_pkg::hs_done: next_jstate = dht_pkg::hs_done;
				default: next_jstate = dht_pkg::hs_idle;
			endcase
		end
	end

	always_comb begin
		next_jcnt = jcnt;
		if (wr_load_a) begin
			next_jcnt = j_up ? 32'h00000000 : hwdata;
		end else if (jgo) begin
			if (is_rtc) begin
				if (sec_tick) next_jcnt = rtc_next;
			end else if (jend) begin
				next_jcnt = j_oneshot ? jcnt : jstart;
			end else begin
				next_jcnt = jstep;
			end
		end
	end

	dht_half #(.W(HALF_W)) u_half_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.mode(mode_a),
		.up(up_a),
		.ctl(hctl_a),
		.halt(debug_halt),
		.chain_in(chain_trig_in),
		.cap_in(cap_a_in),
		.load(load_in_a),
		.load_wr(wr_load_a),
		.match(match_a[HALF_W-1:0]),
		.value(val_a),
		.capture(cap_a),
		.evt(evt_a),
		.pwm_out(pwm_a),
		.trig_out(htrig_a)
	);

	// Half B follows half A in the trigger chain.
	dht_half #(.W(HALF_W)) u_half_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.mode(mode_b),
		.up(up_b),
		.ctl(hctl_b),
		.halt(debug_halt),
		.chain_in(evt_a.timeout),
		.cap_in(cap_b_in),
		.load(load_in_b),
		.load_wr(wr_load_b),
		.match(match_b[HALF_W-1:0]),
		.value(val_b),
		.capture(cap_b),
		.evt(evt_b),
		.pwm_out(pwm_b),
		.trig_out(htrig_b)
	);

	// Writes take no wait state; only a read stalls, to fetch from the registered address.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= dht_pkg::word_reset;
		end else begin
			if (addr_ok) addr_q <= haddr[7:0];
			wr_pend <= addr_ok & hwrite;
			rd_pend <= addr_ok & ~hwrite;
			hreadyout <= ~(addr_ok & ~hwrite);
			if (rd_pend) hrdata <= rd_mux;
		end
	end

	// A configuration write outranks a control write; one transfer cannot carry both anyway.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= dht_pkg::cfg_reset;
			ctl_a <= dht_pkg::ctl_reset;
			ctl_b <= dht_pkg::ctl_reset;
		end else if (wr_cfg) begin
			cfg <= hwdata[11:0];
			ctl_a.en <= 1'b0;
			ctl_b.en <= 1'b0;
		end else begin
			if (ctrl_a_hit) ctl_a <= new_ctl;
			if (ctrl_b_hit) ctl_b <= new_ctl;
		end
	end

	// The interrupt follows the next status, so it rises on the same edge as its status bit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			load_a <= dht_pkg::word_reset;
			load_b <= dht_pkg::word_reset;
			match_a <= dht_pkg::word_reset;
			match_b <= dht_pkg::word_reset;
			mask <= dht_pkg::word_reset;
			status <= dht_pkg::word_reset;
			irq <= 1'b0;
		end else begin
			if (wr_load_a) load_a <= hwdata;
			if (wr_load_b) load_b <= hwdata;
			if (wr_match_a) match_a <= hwdata;
			if (wr_match_b) match_b <= hwdata;
			if (wr_mask) mask <= hwdata & dht_pkg::status_valid;
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// The divider restarts whenever clock mode is left, so every second starts whole.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			jstate <= dht_pkg::hs_idle;
			jcnt <= dht_pkg::word_reset;
			div_cnt <= dht_pkg::word_reset;
			rtc_prev <= 1'b0;
		end else begin
			jstate <= next_jstate;
			jcnt <= next_jcnt;
			rtc_prev <= rtc_clk_in;
			if (!(jen & is_rtc)) begin
				div_cnt <= dht_pkg::word_reset;
			end else if (jgo & rtc_edge) begin
				div_cnt <= sec_tick ? dht_pkg::word_reset : div_cnt + 32'h00000001;
			end
		end
	end

	// The pin turns around only in PWM mode; capture modes keep it an input.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_a_out <= 1'b0;
			cap_b_out <= 1'b0;
			cap_a_oe_n <= 1'b1;
			cap_b_oe_n <= 1'b1;
			trig_a <= 1'b0;
			trig_b <= 1'b0;
		end else begin
			cap_a_out <= pwm_a;
			cap_b_out <= pwm_b;
			cap_a_oe_n <= ~(split & (mode_a == dht_pkg::half_pwm_mode));
			cap_b_oe_n <= ~(split & (mode_b == dht_pkg::half_pwm_mode));
			trig_a <= split ? htrig_a : (j_tmo & ctl_a.trig_en);
			trig_b <= split & htrig_b;
		end
	end
endmodule // dht_timer

// >>> dht_timer_assertions.sv
/*
 * Port-level checker for the dual half timer, bound to the top module.
 * Assumes one AHB-Lite master that issues single word transfers.
 */
`timescale 1ns/1ps
module dht_timer_assertions (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [31:0] hwdata,
	input logic hready,
	input logic hreadyout,
	input logic cap_a_oe_n,
	input logic cap_b_oe_n,
	input logic trig_a,
	input logic trig_b,
	input logic irq
);
	logic wr_ph;
	logic [7:0] wr_addr;
	logic mask_nz;
	wire take = hsel && hready && htrans[1];
	wire cfg_wr = wr_ph && wr_addr == dht_pkg::reg_cfg;
	wire mask_wr = wr_ph && wr_addr == dht_pkg::reg_mask;
	wire dis_wr = wr_ph && wr_addr == dht_pkg::reg_ctrl && hwdata[16] && !hwdata[0];

	// Tracks the data phase of a write so that effects can be tied to their cause.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'b0;
			wr_addr <= 8'h00;
			mask_nz <= 1'b0;
		end else begin
			wr_ph <= take && hwrite;
			wr_addr <= haddr[7:0];
			mask_nz <= mask_wr ? |hwdata : mask_nz;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_rd_take;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_trig_quiet;
		(!trig_a && !trig_b) [*4];
	endsequence

	property p_reset_idle;
		$rose(hresetn) |-> !irq && !trig_a && !trig_b && cap_a_oe_n && cap_b_oe_n && hreadyout;
	endproperty
	property p_read_wait;
		s_rd_take |=> s_rd_answer;
	endproperty
	property p_trig_pulse;
		trig_a |=> !trig_a;
	endproperty
	property p_mask_off;
		mask_wr && hwdata == 32'h00000000 |-> ##[1:3] !irq;
	endproperty
	property p_irq_needs_mask;
		$rose(irq) |-> mask_nz;
	endproperty
	property p_cfg_stop;
		cfg_wr |-> ##3 s_trig_quiet;
	endproperty
	property p_disable_stop;
		dis_wr |-> ##3 (!trig_a [*4]);
	endproperty
	property p_oe_by_write;
		$changed(cap_b_oe_n) |-> $past(wr_ph) || $past(wr_ph, 2) || $past(wr_ph, 3);
	endproperty

	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");
	a_mask_off: assert property (p_mask_off) else $error("irq stays with mask cleared");
	a_irq_needs_mask: assert property (p_irq_needs_mask) else $error("irq rose with mask empty");
	a_cfg_stop: assert property (p_cfg_stop) else $error("trigger after configuration write");
	a_disable_stop: assert property (p_disable_stop) else $error("trigger after disable");
	a_oe_by_write: assert property (p_oe_by_write) else $error("pin direction changed unprompted");
endmodule // dht_timer_assertions

bind dht_timer dht_timer_assertions u_dht_timer_assertions (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.cap_a_oe_n(cap_a_oe_n), .cap_b_oe_n(cap_b_oe_n), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));

// >>> dht_timer_pad.sv
/*
 * Reserved for pad wrappers of the dual half timer; it holds no logic.
 * Assumes nothing of its surroundings.
 */

// >>> tb.sv
/*
 * Self-checking bench for the dual half timer, driving AHB-Lite and the pins.
 * Assumes the checker binds itself and RTC_DIV may be shortened to 4.
 */
`timescale 1ns/1ps
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic debug_halt = 1'b0;
	logic chain_trig_in = 1'b0;
	logic cap_b_in = 1'b0;
	logic rtc_clk_in = 1'b0;
	int n_hi = 0;
	logic [31:0] hrdata, rdat, lval;
	logic hreadyout, hresp, cap_a_out, cap_a_oe_n, cap_b_out, cap_b_oe_n, trig_a, trig_b, irq;
	logic [31:0] exp_q[$];
	logic [31:0] got_q[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_trig = 0;
	int seed = 43811;
	// Each row is a configuration word and an A control byte.
	localparam logic [6:0][19:0] plan_tab = {20'h00921, 20'h00001, 20'h01421, 20'h00441, 20'h00411,
		20'h00401, 20'h00421};

	dht_timer #(.RTC_DIV(4)) u_dht_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .debug_halt(debug_halt), .chain_trig_in(chain_trig_in),
		.rtc_clk_in(rtc_clk_in), .cap_a_in(1'b0), .cap_b_in(cap_b_in), .cap_a_out(cap_a_out),
		.cap_a_oe_n(cap_a_oe_n), .cap_b_out(cap_b_out), .cap_b_oe_n(cap_b_oe_n), .trig_a(trig_a),
		.trig_b(trig_b), .irq(irq));

	initial forever #50 hclk = ~hclk;

	always @(posedge hclk) if (trig_a === 1'b1) n_trig++;

	task automatic note(input logic [31:0] got, input logic [31:0] exp);
		exp_q.push_back(exp);
		got_q.push_back(got);
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdat = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		note(rdat, exp);
	endtask

	// A bounded wait, so a dead interrupt shows as a mismatch, not a hang.
	task automatic wait_irq(input logic v);
		for (int k = 0; k < 300 && irq !== v; k++) @(posedge hclk);
		note({31'h0, irq}, {31'h0, v});
	endtask

	task automatic close_out();
		@(posedge hclk);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin : monitor
		logic [31:0] g, e;
		forever begin
			wait (got_q.size() > 0);
			g = got_q.pop_front();
			e = exp_q.pop_front();
			cmp_count++;
			if (g !== e) begin
				n_mismatch++;
				$display("ERROR %0t got %h expected %h", $time, g, e);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end

	initial begin : main
		logic [19:0] row;
		logic per;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a < 'h34; a += 4) rd(8'(a), 32'h0);
		wr(8'h30, $random(seed));
		rd(8'h30, 32'h0);
		wr(dht_pkg::reg_mask, 32'h1);
		for (int i = 0; i < 7; i++) begin
			row = plan_tab[i];
			per = (i == 4 || i == 6);
			lval = 32'h2 + {29'h0, 3'($random(seed))};
			wr(dht_pkg::reg_cfg, {20'h0, row[19:8]});
			wr(dht_pkg::reg_load_a, lval);
			rd(dht_pkg::reg_value_a, (i == 6) ? 32'h0 : lval);
			debug_halt <= (i == 2);
			n_trig = 0;
			wr(dht_pkg::reg_ctrl, {15'h0, 1'b1, 8'h0, row[7:0]});
			if (i == 2 || i == 3) begin
				repeat (30) @(posedge hclk);
				rd(dht_pkg::reg_value_a, lval);
				debug_halt <= 1'b0;
				chain_trig_in <= 1'b1;
				@(posedge hclk);
				chain_trig_in <= 1'b0;
			end
			wait_irq(1'b1);
			repeat (20) @(posedge hclk);
			note(per ? 32'(n_trig >= 2) : 32'(n_trig), 32'(row[5]));
			if (!per) rd(dht_pkg::reg_value_a, 32'h0);
			rd(dht_pkg::reg_masked, 32'h1);
			wr(dht_pkg::reg_cfg, {20'h0, row[19:8]});
			rd(dht_pkg::reg_ctrl, {24'h0, row[7:1], 1'b0});
			wr(dht_pkg::reg_status, 32'h1);
			wait_irq(1'b0);
		end
		wr(dht_pkg::reg_cfg, 32'h2);
		wr(dht_pkg::reg_load_a, 32'h0);
		wr(dht_pkg::reg_match_a, 32'h2);
		wr(dht_pkg::reg_mask, 32'h8);
		wr(dht_pkg::reg_ctrl, 32'h00010001);
		repeat (8) begin
			repeat (2) @(posedge hclk);
			rtc_clk_in <= 1'b1;
			repeat (2) @(posedge hclk);
			rtc_clk_in <= 1'b0;
		end
		wait_irq(1'b1);
		rd(dht_pkg::reg_value_a, 32'h2);
		rd(dht_pkg::reg_masked, 32'h8);
		wr(dht_pkg::reg_status, 32'h8);
		wait_irq(1'b0);
		wr(dht_pkg::reg_cfg, 32'h204);
		for (int s = 0; s < 3; s++) begin
			wr(dht_pkg::reg_load_b, 32'h14);
			wr(dht_pkg::reg_ctrl, {14'h0, 2'h2, 13'h0, (s == 2) ? dht_pkg::both_edge_select : 2'(s), 1'b1});
			repeat (3) @(posedge hclk);
			repeat (3) begin
				cap_b_in <= 1'b1;
				repeat (2) @(posedge hclk);
				cap_b_in <= 1'b0;
				repeat (2) @(posedge hclk);
			end
			repeat (3) @(posedge hclk);
			rd(dht_pkg::reg_value_b, (s == 2) ? 32'd14 : 32'd17);
		end
		wr(dht_pkg::reg_cfg, 32'h304);
		wr(dht_pkg::reg_load_b, 32'h14);
		wr(dht_pkg::reg_ctrl, 32'h00020001);
		repeat (3) @(posedge hclk);
		cap_b_in <= 1'b1;
		repeat (3) @(posedge hclk);
		cap_b_in <= 1'b0;
		repeat (2) @(posedge hclk);
		rd(dht_pkg::reg_capture, 32'h00120000);
		rd(dht_pkg::reg_status, 32'h400);
		wr(dht_pkg::reg_status, 32'h400);
		wr(dht_pkg::reg_cfg, 32'h404);
		for (int v = 0; v < 2; v++) begin
			wr(dht_pkg::reg_ctrl, {14'h0, 2'h3, 12'h0, 1'(v), 3'h0});
			repeat (3) @(posedge hclk);
			note({30'h0, cap_b_oe_n, cap_b_out}, {30'h0, 1'b0, 1'(v)});
			rd(dht_pkg::reg_ctrl, {20'h0, 1'(v), 7'h0, 1'(v), 3'h0});
		end
		wr(dht_pkg::reg_load_b, 32'h9);
		wr(dht_pkg::reg_match_b, 32'h4);
		wr(dht_pkg::reg_ctrl, 32'h00020001);
		repeat (5) @(posedge hclk);
		repeat (20) begin
			@(posedge hclk);
			n_hi += int'(cap_b_out);
		end
		note(32'(n_hi), 32'ha);
		note({29'h0, hresp, cap_a_oe_n, cap_a_out}, {29'h0, 1'b0, 1'b1, 1'b1});
		wr(dht_pkg::reg_mask, 32'h0);
		repeat (4) @(posedge hclk);
		close_out();
	end
endmodule // tb
